// ==== relay_mux_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module relay_mux_asserts (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic        avs_waitrequest,
	input wire logic [53:0] contact_close,
	input wire logic        sync_out_pin,
	input wire logic        sync_out_bus,
	input wire logic        ready_indicator,
	input wire logic        run_mode_indicator
);
	logic [7:0]  ctrl_q;
	logic [10:0] cnt_q;
	wire         st_wr = avs_write && avs_address == 8'h00;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Shadow of control, saturating uptime
	always @(posedge clk) begin
		ctrl_q <= !resetn ? 8'h00 : (avs_write && avs_address == 8'h04) ? avs_writedata[7:0] : ctrl_q;
		cnt_q  <= !resetn ? 11'h000 : cnt_q + {10'h000, cnt_q != 11'h7ff};
	end
	AST_RST_OPEN: assert property ($rose(resetn) |-> contact_close == 54'h0)
		else $error("contact closed after reset");
	AST_READY_DARK: assert property (cnt_q < 11'd1001 |-> !ready_indicator)
		else $error("ready lit early");
	AST_READY_LIT: assert property (cnt_q > 11'd1000 |-> ready_indicator)
		else $error("ready dark late");
	AST_MODE: assert property (avs_write && avs_address == 8'h04 |-> ##2 run_mode_indicator == ctrl_q[0])
		else $error("mode indicator wrong");
	AST_BREAK: assert property ($changed(contact_close) && contact_close != 54'h0 && !ctrl_q[1]
		|-> $past(contact_close) == 54'h0)
		else $error("make without break");
	AST_RD_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read wait wrong");
	AST_WR_NOWAIT: assert property (avs_write |-> !avs_waitrequest)
		else $error("write waited");
	AST_SOUT_PIN: assert property (st_wr && ctrl_q[2] && !ctrl_q[4] |-> ##[1:2] sync_out_pin == !ctrl_q[3])
		else $error("sync pin not pulsed");
	AST_SOUT_BUS: assert property (st_wr && ctrl_q[2] && ctrl_q[4] |-> ##[1:2] sync_out_bus == !ctrl_q[3])
		else $error("sync bus not pulsed");
endmodule // relay_mux_asserts
bind relay_mux_ctrl relay_mux_asserts chk_u (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_waitrequest, .contact_close, .sync_out_pin, .sync_out_bus, .ready_indicator, .run_mode_indicator);
`default_nettype wire

// ==== relay_mux_ctrl.v ====
`timescale 1ns/1ns
`default_nettype none
`include "relay_mux_regs.vh"

//Contract
// R1 - The ready indicator lights only once the board is up and running, otherwise dark.
// R2 - The mode indicator is off in configuration mode and on in operation mode.
// R3 - Each channel has three independent contacts A, B and C to the common terminal.
// R4 - One write of the state word updates all channels together as one group.
// R5 - By default all closed contacts open before the new state's contacts close.
// R6 - A control bit disables break-before-make so the new state is applied directly.
// R7 - All contacts stay open for a programmable number of microseconds between break and make.
// R8 - After power-up or reboot every contact of every channel is open.
// R9 - The host keeps updates at or below the maximum rate, break interval included.
// R10 - With sync out enabled, the sync output pulses whenever a relay change is programmed.
// R11 - Software sets the sync out pulse width and its active level.
// R12 - The sync output can go to the connector pin or onto the chassis bus lines.
// R13 - With sync in enabled, a programmed change waits for a trigger on the sync input.
// R14 - Sync in triggers on level or edge, high/rising or low/falling.
// R15 - A newer write while waiting for the trigger replaces the pending state.
module relay_mux_ctrl (
	input  wire                 clk,
	input  wire                 resetn,
	input  wire [7:0]           avs_address,
	input  wire                 avs_read,
	input  wire                 avs_write,
	input  wire [31:0]          avs_writedata,
	output reg  [31:0]          avs_readdata,
	output wire                 avs_waitrequest,
	input  wire                 sync_in_pin,
	output reg  [`STATE_W-1:0]  contact_close,
	output reg                  sync_out_pin,
	output reg                  sync_out_bus,
	output reg                  ready_indicator,
	output reg                  run_mode_indicator
);
	localparam [3:0] ST_IDLE  = 4'b0001;
	localparam [3:0] ST_WAIT  = 4'b0010;
	localparam [3:0] ST_BREAK = 4'b0100;
	localparam [3:0] ST_MAKE  = 4'b1000;

	reg [3:0]            state_q;
	reg [`STATE_W-1:0]   pend_q;
	reg [`CTRL_WIDTH-1:0] ctrl_q;
	reg [15:0]           bbm_us_q;
	reg [15:0]           sw_us_q;
	reg [15:0]           dly_q;
	reg [15:0]           sw_q;
	reg                  sw_act_q;
	reg [10:0]           pwr_q;
	reg                  rd_ack_q;
	wire                 tick;
	wire                 trig;
	wire                 wr_state;
	wire                 sout_lvl;

	function hit;
		input [7:0] a;
		input [7:0] r;
		begin
			hit = (a == r);
		end
	endfunction

	// Reads take one wait cycle so data comes from flops
	assign avs_waitrequest = avs_read & ~rd_ack_q;
	assign wr_state = avs_write & hit(avs_address, `REG_STATE);

	// Restart at break so the gap never runs short
	us_tick u_tick (
		.clk    (clk),
		.resetn (resetn),
		.clear  (wr_state | state_q[2]),
		.tick   (tick)
	);

	// R14 level or edge
	sync_in_detect u_sin (
		.clk        (clk),
		.resetn     (resetn),
		.pin        (sync_in_pin),
		.edge_mode  (ctrl_q[`CTRL_SIN_EDGE]),
		.low_active (ctrl_q[`CTRL_SIN_POL]),
		.trigger    (trig)
	);

	always @(posedge clk) begin
		if (!resetn) begin
			ctrl_q   <= `CTRL_RST;
			bbm_us_q <= `BBM_DELAY_RST;
			sw_us_q  <= `SYNC_WIDTH_RST;
		end else if (avs_write) begin
			if (hit(avs_address, `REG_CTRL))
				ctrl_q <= avs_writedata[`CTRL_WIDTH-1:0];
			if (hit(avs_address, `REG_BBM_DELAY))
				bbm_us_q <= avs_writedata[15:0];
			if (hit(avs_address, `REG_SYNC_WIDTH))
				sw_us_q <= avs_writedata[15:0];
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			rd_ack_q     <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			rd_ack_q <= avs_read & ~rd_ack_q;
			if (avs_read & ~rd_ack_q) begin
				case (avs_address)
				`REG_STATE:      avs_readdata <= pend_q[31:0];
				`REG_CTRL:       avs_readdata <= {24'h000000, ctrl_q};
				`REG_BBM_DELAY:  avs_readdata <= {16'h0000, bbm_us_q};
				`REG_SYNC_WIDTH: avs_readdata <= {16'h0000, sw_us_q};
				`REG_STATUS:     avs_readdata <= {28'h0000000, sw_act_q,
					~state_q[0], state_q[1], ready_indicator};
				`REG_APPLIED:    avs_readdata <= contact_close[31:0];
				default:         avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Main update sequencer
	always @(posedge clk) begin
		if (!resetn) begin
			state_q       <= ST_IDLE;
			pend_q        <= {`STATE_W{1'b0}};
			dly_q         <= 16'h0000;
			// R8 all open
			contact_close <= {`STATE_W{1'b0}};
		end else begin
			// R15 latest wins
			if (wr_state)
				pend_q <= {pend_q[53:32], avs_writedata};
			if (avs_write & hit(avs_address, `REG_STATE_HI))
				pend_q[53:32] <= avs_writedata[21:0];
			case (state_q)
			ST_IDLE: begin
				if (wr_state)
					// R13 hold for sync in
					state_q <= ctrl_q[`CTRL_SIN_EN] ? ST_WAIT : ST_BREAK;
			end
			ST_WAIT: begin
				if (trig)
					state_q <= ST_BREAK;
			end
			ST_BREAK: begin
				// R6 skip break
				if (ctrl_q[`CTRL_BBM_DIS]) begin
					// R4 group update
					contact_close <= pend_q;
					state_q       <= ST_IDLE;
				end else begin
					// R5 open first
					contact_close <= {`STATE_W{1'b0}};
					dly_q         <= bbm_us_q;
					state_q       <= ST_MAKE;
				end
			end
			ST_MAKE: begin
				// R7 open interval
				if (dly_q == 16'h0000) begin
					// R3 per contact bits
					contact_close <= pend_q;
					state_q       <= ST_IDLE;
				end else if (tick)
					dly_q <= dly_q - 16'd1;
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// R11 width and level
	assign sout_lvl = sw_act_q ^ ctrl_q[`CTRL_SOUT_POL];

	always @(posedge clk) begin
		if (!resetn) begin
			sw_act_q     <= 1'b0;
			sw_q         <= 16'h0000;
			sync_out_pin <= 1'b0;
			sync_out_bus <= 1'b0;
		end else begin
			// R10 pulse on program
			if (wr_state & ctrl_q[`CTRL_SOUT_EN]) begin
				sw_act_q <= 1'b1;
				sw_q     <= sw_us_q;
			end else if (sw_act_q & tick) begin
				if (sw_q <= 16'd1)
					sw_act_q <= 1'b0;
				sw_q <= sw_q - 16'd1;
			end
			// R12 pin or bus
			sync_out_pin <= ctrl_q[`CTRL_SOUT_BUS] ? ctrl_q[`CTRL_SOUT_POL] : sout_lvl;
			sync_out_bus <= ctrl_q[`CTRL_SOUT_BUS] ? sout_lvl : ctrl_q[`CTRL_SOUT_POL];
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			pwr_q              <= 11'h000;
			ready_indicator    <= 1'b0;
			run_mode_indicator <= 1'b0;
		end else begin
			// R1 ready after settle
			if (pwr_q != `POWER_UP_CYCLES)
				pwr_q <= pwr_q + 11'd1;
			ready_indicator    <= (pwr_q == `POWER_UP_CYCLES);
			// R2 mode indicator
			run_mode_indicator <= ctrl_q[`CTRL_RUN_MODE];
		end
	end
endmodule // relay_mux_ctrl
`default_nettype wire

// ==== relay_mux_regs.vh ====
`ifndef RELAY_MUX_REGS_VH
`define RELAY_MUX_REGS_VH

// Register word offsets (byte address)
`define REG_STATE       8'h00
`define REG_CTRL        8'h04
`define REG_BBM_DELAY   8'h08
`define REG_SYNC_WIDTH  8'h0c
`define REG_STATUS      8'h10
`define REG_APPLIED     8'h14
`define REG_STATE_HI    8'h18

// Control register fields
`define CTRL_RUN_MODE   0
`define CTRL_BBM_DIS    1
`define CTRL_SOUT_EN    2
`define CTRL_SOUT_POL   3
`define CTRL_SOUT_BUS   4
`define CTRL_SIN_EN     5
`define CTRL_SIN_EDGE   6
`define CTRL_SIN_POL    7
`define CTRL_WIDTH      8

// Status register fields
`define STAT_READY      0
`define STAT_PENDING    1
`define STAT_BUSY       2
`define STAT_SYNC_OUT   3

// Channel layout
`define NUM_CH          18
`define STATE_W         54

// Reset values
`define BBM_DELAY_RST   16'h0000
`define SYNC_WIDTH_RST  16'h0001
`define CTRL_RST        8'h00

// Timing
`define CLK_MHZ         100
`define US_CYCLES       (`CLK_MHZ)
`define US_LAST         7'd99
`define POWER_UP_US     10
`define POWER_UP_CYCLES (`POWER_UP_US * `US_CYCLES)

`endif

// ==== sync_in_detect.v ====
`timescale 1ns/1ns
`default_nettype none

module sync_in_detect (
	input  wire clk,
	input  wire resetn,
	input  wire pin,
	input  wire edge_mode,
	input  wire low_active,
	output wire trigger
);
	reg s1_q;
	reg s2_q;
	reg prev_q;
	wire lvl;

	// Two stages before any logic reads the pin
	always @(posedge clk) begin
		if (!resetn) begin
			s1_q   <= 1'b0;
			s2_q   <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			s1_q   <= pin;
			s2_q   <= s1_q;
			prev_q <= s2_q ^ low_active;
		end
	end

	assign lvl     = s2_q ^ low_active;
	assign trigger = edge_mode ? (lvl & ~prev_q) : lvl;
endmodule // sync_in_detect
`default_nettype wire

// ==== sync_source.sv ====
`timescale 1ns/1ns
`default_nettype none
module sync_source (
	input wire logic clk,
	input wire logic fire,
	input wire logic low_act,
	output logic     pin
);
	int n = 0;
	always @(posedge clk) n <= fire ? 20 : (n > 0 ? n - 1 : 0);
	assign pin = (n > 0) ^ low_act;
endmodule // sync_source
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        clk = 0, resetn = 0, avs_read = 0, avs_write = 0, fire = 0, low_act = 0;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'd55, q[$];
	logic [53:0] contact_close, v, old;
	wire         avs_waitrequest, sync_in_pin, sync_out_pin, sync_out_bus, ready_indicator, run_mode_indicator;
	int          fail_count = 0, compares = 0, cyc = 0;
	relay_mux_ctrl dut_u (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .sync_in_pin, .contact_close, .sync_out_pin, .sync_out_bus, .ready_indicator,
		.run_mode_indicator);
	sync_source src_u (.clk, .fire, .low_act, .pin(sync_in_pin));
	initial forever #5 clk = ~clk;
	function automatic [53:0] rnd();
		for (int k = 0; k < 2; k++) begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			rnd = {rnd[21:0], seed};
		end
	endfunction
	task check(input string nm, input [63:0] seen, input [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task finish_test;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task bus(input [7:0] a, input [31:0] d, input is_rd);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= is_rd;
		avs_write <= !is_rd;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		avs_read <= 0;
		avs_write <= 0;
		@(posedge clk);
	endtask
	task rd(input [7:0] a, input [31:0] e);
		q.push_back(e);
		bus(a, 32'h0, 1);
	endtask
	// High word first, low word starts update
	task st(input [53:0] s);
		bus(8'h18, {10'h000, s[53:32]}, 0);
		bus(8'h00, s[31:0], 0);
	endtask
	always @(posedge clk) begin
		cyc++;
		// Bound well above the ~5100 cycles used
		if (cyc == 30000) begin
			fail_count++;
			finish_test;
		end else if (avs_read && !avs_waitrequest) check("readdata", avs_readdata, q.pop_front());
	end
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		check("contacts", contact_close, 0);
		check("ready", ready_indicator, 0);
		repeat (1010) @(posedge clk);
		check("ready", ready_indicator, 1);
		rd(8'h10, 32'h1);
		bus(8'h04, 32'h1, 0);
		@(posedge clk);
		check("mode", run_mode_indicator, 1);
		bus(8'h04, 32'h2, 0);
		@(posedge clk);
		check("mode", run_mode_indicator, 0);
		bus(8'h08, 32'h2, 0);
		bus(8'h0c, 32'h3, 0);
		$display("test reset and mode done");
		// Updates spaced by completion, far faster than the host limit
		old = rnd();
		st(old);
		@(posedge clk);
		check("direct", contact_close, old);
		bus(8'h04, 32'h0, 0);
		v = rnd();
		st(v);
		@(posedge clk);
		check("break", contact_close, 0);
		repeat (150) @(posedge clk);
		check("gap", contact_close, 0);
		repeat (60) @(posedge clk);
		check("make", contact_close, v);
		rd(8'h14, v[31:0]);
		$display("test switching done");
		for (int i = 0; i < 4; i++) begin
			bus(8'h04, 32'h4 | (i << 3), 0);
			st(rnd());
			repeat (50) @(posedge clk);
			check("sync pin", sync_out_pin, i[0] ^ !i[1]);
			check("sync bus", sync_out_bus, i[0] ^ i[1]);
			repeat (300) @(posedge clk);
			check("sync end", sync_out_pin, i[0]);
		end
		$display("test sync out done");
		for (int i = 0; i < 4; i++) begin
			low_act <= i[1];
			bus(8'h04, 32'h20 | (i << 6), 0);
			old = contact_close;
			st(rnd());
			v = rnd();
			st(v);
			repeat (300) @(posedge clk);
			check("held", contact_close, old);
			fire <= 1;
			@(posedge clk);
			fire <= 0;
			repeat (300) @(posedge clk);
			check("fired", contact_close, v);
		end
		$display("test sync in done");
		resetn <= 0;
		repeat (3) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		@(posedge clk);
		check("reboot", contact_close, 0);
		check("ready", ready_indicator, 0);
		$display("test reboot done");
		finish_test;
	end
endmodule // testbench
`default_nettype wire

// ==== us_tick.v ====
`timescale 1ns/1ns
`default_nettype none
`include "relay_mux_regs.vh"

module us_tick (
	input  wire       clk,
	input  wire       resetn,
	input  wire       clear,
	output reg        tick
);
	localparam [6:0] LAST = `US_LAST;
	reg [6:0] cnt_q;

	always @(posedge clk) begin
		if (!resetn) begin
			cnt_q <= 7'h00;
			tick  <= 1'b0;
		end else if (clear) begin
			cnt_q <= 7'h00;
			tick  <= 1'b0;
		end else begin
			tick  <= (cnt_q == LAST);
			cnt_q <= (cnt_q == LAST) ? 7'h00 : cnt_q + 7'd1;
		end
	end
endmodule // us_tick
`default_nettype wire
